/* File: src/flame_cfg_pkg.sv */
/*
 * Constants, register map and carrier types for the flame decision and
 * configuration check block.
 * Assumes a 200 MHz system clock and an AXI4-Lite master.
 */
`default_nettype none
package flame_cfg_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 200_000_000;
    localparam int MISMATCH_TIME_S = 8;
    localparam int SAFETY_TIME_MS  = 1000;
    localparam int MS_CYCLES       = CLK_HZ / 1000;
    localparam int MISMATCH_MS     = MISMATCH_TIME_S * 1000;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_INT_STAT = 8'h04;
    localparam logic [7:0] OFS_INT_EN   = 8'h08;
    localparam logic [7:0] OFS_INT_CLR  = 8'h0C;
    localparam logic [7:0] OFS_MEAS     = 8'h10;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // Switch decoding
    // ------------------------------------------------------------
    localparam logic [3:0]  ROT_RESET  = 4'h0;
    localparam logic [7:0]  DIP_RESET  = 8'h24;
    localparam logic [11:0] INT_STEP   = 12'h100;
    localparam logic [11:0] FREQ_STEP  = 12'h00F;
    localparam int          GAIN_LSB_A = 2;
    localparam int          GAIN_LSB_B = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] intA;
        logic [3:0] intB;
        logic [3:0] frqA;
        logic [3:0] frqB;
        logic [7:0] dip;
    } chan_sw_s;

    localparam chan_sw_s SW_RESET = '{intA: ROT_RESET, intB: ROT_RESET,
                                      frqA: ROT_RESET, frqB: ROT_RESET,
                                      dip: DIP_RESET};

    typedef enum logic [2:0] {
        FL_OFF  = 3'b001,
        FL_ON   = 3'b010,
        FL_SHUT = 3'b100
    } flame_e;

    typedef struct packed {
        logic rangeChg;
        logic shut;
        logic mism;
        logic flameOff;
        logic flameOn;
    } evt_s;

    typedef struct packed {
        logic [23:0] rsv;
        logic        perEn;
        logic [2:0]  gain;
        logic        activeB;
        logic        shut;
        logic        mism;
        logic        flame;
    } status_s;

    typedef struct packed {
        chan_sw_s [1:0] s1;
        chan_sw_s [1:0] s2;
        logic [1:0]     rng1;
        logic [1:0]     rng2;
        logic [31:0]    tick;
        logic [15:0]    mismMs;
        logic [15:0]    safeMs;
        flame_e         fsm;
        logic           mism;
        logic           activeB;
        logic [2:0]     gain;
        logic           perEn;
        evt_s           intStat;
        evt_s           intEn;
        logic           awHeld;
        logic [7:0]     awAddr;
        logic           wHeld;
        logic [31:0]    wData;
        logic [3:0]     wStrb;
        logic           bValid;
        logic [1:0]     bResp;
        logic           rValid;
        logic [31:0]    rData;
        logic [1:0]     rResp;
    } state_s;
endpackage
`default_nettype wire

/* File: src/flame_decision_config_check.sv */
/*
 * Flame-on decision with dual-channel switch cross-check, range
 * selection, gain curve decode, AXI4-Lite registers and interrupt.
 * Assumes switch and range pins are asynchronous and the measured
 * intensity and flicker values come from logic on sys_clk.
 */
// The AXI4-Lite register port and the register addresses are this design's own decisions.
// Functional notes
// - Both channels decide independently; disagreement leads to shutdown.
// - Differing rotary copies light switch error, shut down after 8 s.
// - Differing gain DIP banks light switch error, shut down after 8 s.
// - Threshold selectors decode 0 to F, lowest to highest.
// - Delivered rotary selectors sit at code 0.
// - Flame-on needs intensity above the active range threshold.
// - Flicker code 0 disables flicker threshold and periodic detection.
// - Nonzero flicker code requires frequency above its threshold.
// - Below threshold, flame-off follows after the safety time.
// - Gain adapts along the curve selected for the active range.
// - DIP banks select one of eight curves per range.
// - DIP 3-5 primary, 6-8 secondary; all-off highest; delivered one lower.
// - Curve number rises monotonically with input gain.
// - Each range has its own settings; only the active set applies.
// - Broken range line falls back to the primary range.
`default_nettype none
module flame_decision_config_check #(
    parameter int unsigned MS_CYCLES_P   = flame_cfg_pkg::MS_CYCLES,
    parameter int unsigned MISMATCH_MS_P = flame_cfg_pkg::MISMATCH_MS,
    parameter int unsigned SAFETY_MS_P   = flame_cfg_pkg::SAFETY_TIME_MS
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    // AXI4-Lite write
    input  wire logic [7:0]               awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    // AXI4-Lite read
    input  wire logic [7:0]               araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    // Switch pins, one copy per channel
    input  wire flame_cfg_pkg::chan_sw_s  swChan1,
    input  wire flame_cfg_pkg::chan_sw_s  swChan2,
    // Range control line
    input  wire logic                     rangeSelB,
    input  wire logic                     rangeLineOk,
    // Measurements
    input  wire logic [11:0]              measIntensity,
    input  wire logic [11:0]              measFreq,
    // Decision and status
    output logic                          flameOn,
    output logic                          switchErrLed,
    output logic                          errShutdown,
    output logic                          activeRangeB,
    output logic [2:0]                    gainCurve,
    output logic                          periodicDetEn,
    output logic                          irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    flame_cfg_pkg::state_s st;
    flame_cfg_pkg::state_s nxt;
    flame_cfg_pkg::evt_s   evt;
    flame_cfg_pkg::evt_s   clrMask;
    flame_cfg_pkg::status_s stat;

    logic [3:0]  iCode [2];
    logic [3:0]  fCode [2];
    logic [2:0]  dipSel [2];
    logic [2:0]  crv [2];
    logic [11:0] intThr [2];
    logic [11:0] frqThr [2];
    logic [1:0]  raw;
    logic        rawAct;
    logic        swMism;
    logic        mismNow;
    logic        msTick;
    logic        shutNow;
    logic        awTake;
    logic        wTake;
    logic        arTake;
    logic        haveAw;
    logic        haveW;
    logic [7:0]  wAddr;
    logic [31:0] wDat;
    logic [3:0]  wStb;

    // ------------------------------------------------------------
    // Per-channel decode of the active range
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_chan
        // Range select picks one complete set of switches
        assign iCode[g]  = st.activeB ? st.s2[g].intB : st.s2[g].intA;
        assign fCode[g]  = st.activeB ? st.s2[g].frqB : st.s2[g].frqA;
        assign dipSel[g] = st.activeB
                         ? st.s2[g].dip[flame_cfg_pkg::GAIN_LSB_B +: 3]
                         : st.s2[g].dip[flame_cfg_pkg::GAIN_LSB_A +: 3];
        // All-off means highest curve, so curve index is inverted
        assign crv[g]    = ~dipSel[g];
        // Code 0 lowest, F highest
        assign intThr[g] = 12'(iCode[g] * flame_cfg_pkg::INT_STEP);
        assign frqThr[g] = 12'(fCode[g] * flame_cfg_pkg::FREQ_STEP);
        assign raw[g]    = (measIntensity > intThr[g])
                         && ((fCode[g] == 4'h0)
                             || (measFreq > frqThr[g]));
    end

    // Both channels must reach the same verdict
    assign rawAct  = raw[0] & raw[1];
    // Whole DIP bank compared, safety-time bits included
    assign swMism  = (st.s2[0] != st.s2[1]);
    assign mismNow = swMism | (raw[0] ^ raw[1]);
    assign msTick  = (st.tick == 32'(MS_CYCLES_P - 1));
    assign shutNow = mismNow && msTick
                   && (st.mismMs == 16'(MISMATCH_MS_P - 1));

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    // One write in flight: channels close while a response waits
    assign awready = !st.awHeld && !st.bValid;
    assign wready  = !st.wHeld && !st.bValid;
    assign arready = !st.rValid;
    assign awTake  = awvalid && awready;
    assign wTake   = wvalid && wready;
    assign arTake  = arvalid && arready;
    assign haveAw  = st.awHeld || awTake;
    assign haveW   = st.wHeld || wTake;
    assign wAddr   = st.awHeld ? st.awAddr : awaddr;
    assign wDat    = st.wHeld ? st.wData : wdata;
    assign wStb    = st.wHeld ? st.wStrb : wstrb;

    assign stat = '{rsv: 24'h0, perEn: st.perEn, gain: st.gain,
                    activeB: st.activeB,
                    shut: (st.fsm == flame_cfg_pkg::FL_SHUT),
                    mism: st.mism,
                    flame: (st.fsm == flame_cfg_pkg::FL_ON)};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt     = st;
        evt     = '0;
        clrMask = '0;

        // Two-stage synchronisers for all switch and range pins
        nxt.s1[0] = swChan1;
        nxt.s1[1] = swChan2;
        nxt.s2    = st.s1;
        nxt.rng1  = {rangeLineOk, rangeSelB};
        nxt.rng2  = st.rng1;
        // Dead line reads as primary range
        nxt.activeB = st.rng2[1] & st.rng2[0];

        nxt.tick = msTick ? 32'h0 : st.tick + 32'h1;

        // Only an unbroken disagreement accumulates
        nxt.mism = mismNow;
        if (!mismNow) begin
            nxt.mismMs = 16'h0;
        end else if (msTick
                     && (st.mismMs != 16'(MISMATCH_MS_P))) begin
            nxt.mismMs = st.mismMs + 16'h1;
        end

        case (st.fsm)
            flame_cfg_pkg::FL_OFF: begin
                nxt.safeMs = 16'h0;
                if (rawAct) begin
                    nxt.fsm = flame_cfg_pkg::FL_ON;
                end
            end
            flame_cfg_pkg::FL_ON: begin
                if (rawAct) begin
                    nxt.safeMs = 16'h0;
                end else if (msTick) begin
                    // Loss must persist for the whole safety time
                    if (st.safeMs == 16'(SAFETY_MS_P - 1)) begin
                        nxt.fsm    = flame_cfg_pkg::FL_OFF;
                        nxt.safeMs = 16'h0;
                    end else begin
                        nxt.safeMs = st.safeMs + 16'h1;
                    end
                end
            end
            flame_cfg_pkg::FL_SHUT: begin
                nxt.safeMs = 16'h0;
            end
            default: begin
                nxt.fsm = flame_cfg_pkg::FL_SHUT;
            end
        endcase
        // Shutdown is final until reset, the safe reaction
        if (shutNow) begin
            nxt.fsm = flame_cfg_pkg::FL_SHUT;
        end

        // Curve handed to the gain adaptation loop
        nxt.gain  = crv[0];
        nxt.perEn = (fCode[0] != 4'h0) && (fCode[1] != 4'h0);

        evt.flameOn  = (st.fsm != flame_cfg_pkg::FL_ON)
                     && (nxt.fsm == flame_cfg_pkg::FL_ON);
        evt.flameOff = (st.fsm == flame_cfg_pkg::FL_ON)
                     && (nxt.fsm == flame_cfg_pkg::FL_OFF);
        evt.mism     = mismNow && !st.mism;
        evt.shut     = (st.fsm != flame_cfg_pkg::FL_SHUT)
                     && (nxt.fsm == flame_cfg_pkg::FL_SHUT);
        evt.rangeChg = (nxt.activeB != st.activeB);

        // Write channel
        if (awTake) begin
            nxt.awHeld = 1'b1;
            nxt.awAddr = awaddr;
        end
        if (wTake) begin
            nxt.wHeld = 1'b1;
            nxt.wData = wdata;
            nxt.wStrb = wstrb;
        end
        if (st.bValid && bready) begin
            nxt.bValid = 1'b0;
        end
        if (haveAw && haveW && !st.bValid) begin
            nxt.awHeld = 1'b0;
            nxt.wHeld  = 1'b0;
            nxt.bValid = 1'b1;
            nxt.bResp  = flame_cfg_pkg::RESP_OKAY;
            case ({wAddr[7:2], 2'b00})
                flame_cfg_pkg::OFS_INT_EN: begin
                    if (wStb[0]) begin
                        nxt.intEn = wDat[4:0];
                    end
                end
                flame_cfg_pkg::OFS_INT_CLR: begin
                    if (wStb[0]) begin
                        clrMask = wDat[4:0];
                    end
                end
                flame_cfg_pkg::OFS_STATUS,
                flame_cfg_pkg::OFS_INT_STAT,
                flame_cfg_pkg::OFS_MEAS: begin
                    nxt.bResp = flame_cfg_pkg::RESP_OKAY;
                end
                default: begin
                    nxt.bResp = flame_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
        // A new event beats a clear in the same cycle
        nxt.intStat = (st.intStat & ~clrMask) | evt;

        // Read channel
        if (st.rValid && rready) begin
            nxt.rValid = 1'b0;
        end
        if (arTake) begin
            nxt.rValid = 1'b1;
            nxt.rResp  = flame_cfg_pkg::RESP_OKAY;
            case ({araddr[7:2], 2'b00})
                flame_cfg_pkg::OFS_STATUS: begin
                    nxt.rData = stat;
                end
                flame_cfg_pkg::OFS_INT_STAT: begin
                    nxt.rData = {27'h0, st.intStat};
                end
                flame_cfg_pkg::OFS_INT_EN: begin
                    nxt.rData = {27'h0, st.intEn};
                end
                flame_cfg_pkg::OFS_INT_CLR: begin
                    nxt.rData = 32'h0;
                end
                flame_cfg_pkg::OFS_MEAS: begin
                    nxt.rData = {4'h0, measFreq, 4'h0, measIntensity};
                end
                default: begin
                    nxt.rData = 32'h0;
                    nxt.rResp = flame_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st     <= '0;
            // Delivered switch setting until the pins are sampled
            st.s1  <= {2{flame_cfg_pkg::SW_RESET}};
            st.s2  <= {2{flame_cfg_pkg::SW_RESET}};
            st.fsm <= flame_cfg_pkg::FL_OFF;
            st.gain <= ~flame_cfg_pkg::DIP_RESET[flame_cfg_pkg::GAIN_LSB_A
                                                 +: 3];
        end else begin
            st <= nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bvalid        = st.bValid;
    assign bresp         = st.bResp;
    assign rvalid        = st.rValid;
    assign rdata         = st.rData;
    assign rresp         = st.rResp;
    assign flameOn       = (st.fsm == flame_cfg_pkg::FL_ON);
    assign errShutdown   = (st.fsm == flame_cfg_pkg::FL_SHUT);
    assign switchErrLed  = st.mism;
    assign activeRangeB  = st.activeB;
    assign gainCurve     = st.gain;
    assign periodicDetEn = st.perEn;
    assign irq           = |(st.intStat & st.intEn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_FLAME_CAUSE: assert property (
        $rose(flameOn) |-> $past(rawAct))
        else $error("flame-on without both channels above threshold");
    AST_SAFETY_OFF: assert property (
        ($fell(flameOn) && !errShutdown)
        |-> ($past(st.safeMs) == 16'(SAFETY_MS_P - 1)) && $past(msTick))
        else $error("flame-off before the safety time ran out");
    AST_SHUT_TIME: assert property (
        $rose(errShutdown)
        |-> ($past(st.mismMs) == 16'(MISMATCH_MS_P - 1))
            && $past(mismNow))
        else $error("shutdown not at end of mismatch time");
    AST_MISM_RESTART: assert property (
        !mismNow |=> (st.mismMs == 16'h0))
        else $error("mismatch timer not restarted on agreement");
    AST_SHUT_STICKY: assert property (
        errShutdown |=> errShutdown && !flameOn)
        else $error("operation continued after shutdown");
    AST_FALLBACK: assert property (
        !st.rng2[1] |=> !activeRangeB)
        else $error("broken range line did not select primary range");
    AST_FREQ_OFF: assert property (
        (fCode[0] == 4'h0) |=> !periodicDetEn)
        else $error("periodic detection on with flicker code 0");
    AST_GAIN_MAP: assert property (
        1'b1 |=> (3'(gainCurve + $past(dipSel[0])) == 3'h7))
        else $error("gain curve does not follow DIP code");

    CVR_FLAME_ON: cover property ($rose(flameOn));
    CVR_FLAME_OFF: cover property ($fell(flameOn) && !errShutdown);
    CVR_SHUTDOWN: cover property ($rose(errShutdown));
    CVR_RANGE_B: cover property ($rose(activeRangeB));
endmodule
`default_nettype wire

/* File: verif/switch_panel.sv */
/*
 * Model of the duplicated switches and the burner control range line.
 * Assumes the bench changes its commands just after a rising edge.
 */
`default_nettype none
module switch_panel (
    // Clock
    input  wire logic                    sys_clk,
    // Commands from the bench
    input  wire flame_cfg_pkg::chan_sw_s cmdSw,
    input  wire flame_cfg_pkg::chan_sw_s faultMask,
    input  wire logic                    cmdB,
    input  wire logic                    cmdLineOk,
    // Pins towards the block
    output var flame_cfg_pkg::chan_sw_s  swChan1,
    output var flame_cfg_pkg::chan_sw_s  swChan2,
    output var logic                     rangeSelB,
    output var logic                     rangeLineOk
);
    timeunit 1ns;
    timeprecision 100ps;
    flame_cfg_pkg::chan_sw_s want;
    logic                    tog = 1'h0;

    // ----------------------------------------
    // Operator and burner control
    // ----------------------------------------
    always_comb begin
        want = cmdSw;
        want.dip[1:0] = flame_cfg_pkg::DIP_RESET[1:0];
    end

    // Second copy lags one cycle, far inside the allowed window
    always @(posedge sys_clk) begin
        tog <= ~tog;
        swChan1 <= want;
        swChan2 <= swChan1 ^ faultMask;
        rangeLineOk <= cmdLineOk;
        // A broken line carries noise, not the last level
        rangeSelB <= cmdLineOk ? cmdB : tog;
    end
endmodule
`default_nettype wire

/* File: verif/flame_decision_config_check_tb.sv */
/*
 * Self-checking bench: AXI4-Lite tasks, switch panel model, decisions.
 * Assumes the shortened tick, mismatch and safety counts set below.
 */
`default_nettype none
module flame_decision_config_check_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MSC = 10;
    localparam int MMS = 5;
    localparam int SMS = 3;
    logic        sys_clk, rstn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic        rangeSelB, rangeLineOk, cmdB, lineOk, flameOn, irq;
    logic        switchErrLed, errShutdown, activeRangeB, periodicDetEn;
    logic [11:0] measIntensity, measFreq;
    logic [2:0]  gainCurve;
    logic [3:0]  c;
    flame_cfg_pkg::chan_sw_s swChan1, swChan2, sw, fm;
    int          err_count, n_compared;

    flame_decision_config_check #(.MS_CYCLES_P(MSC),
        .MISMATCH_MS_P(MMS), .SAFETY_MS_P(SMS)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .swChan1(swChan1), .swChan2(swChan2), .rangeSelB(rangeSelB),
        .rangeLineOk(rangeLineOk), .measIntensity(measIntensity),
        .measFreq(measFreq), .flameOn(flameOn),
        .switchErrLed(switchErrLed), .errShutdown(errShutdown),
        .activeRangeB(activeRangeB), .gainCurve(gainCurve),
        .periodicDetEn(periodicDetEn), .irq(irq));

    switch_panel panel (.sys_clk(sys_clk), .cmdSw(sw), .faultMask(fm),
        .cmdB(cmdB), .cmdLineOk(lineOk), .swChan1(swChan1),
        .swChan2(swChan2), .rangeSelB(rangeSelB),
        .rangeLineOk(rangeLineOk));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo;
        err_count++;
        $display("BAD t=%0t wait ran out", $time);
        final_report();
    endtask

    function automatic logic [31:0] sel(input int w);
        case (w)
            0: sel = {31'h0, flameOn};
            1: sel = {31'h0, switchErrLed};
            2: sel = {31'h0, errShutdown};
            3: sel = {31'h0, activeRangeB};
            4: sel = {29'h0, gainCurve};
            5: sel = {31'h0, periodicDetEn};
            default: sel = {31'h0, irq};
        endcase
    endfunction

    // Outputs are sampled at the falling edge, away from updates
    task automatic look(input int w, input logic [31:0] v);
        @(negedge sys_clk);
        chk(sel(w), v);
        @(posedge sys_clk);
    endtask

    task automatic await(input int w, input logic [31:0] v, input int hi);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (sel(w) !== v) begin
            @(negedge sys_clk);
            if (++n > hi) tmo();
        end
        chk(sel(w), v);
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic ad, wd, hs;
        n = 0; ad = 0; wd = 0; hs = 0;
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
        while (!(ad && wd)) begin
            @(negedge sys_clk);
            ad = ad | awready;
            wd = wd | wready;
            @(posedge sys_clk);
            if (ad) awvalid <= 1'h0;
            if (wd) wvalid <= 1'h0;
            if (++n > 50) tmo();
        end
        do begin
            @(negedge sys_clk);
            hs = bvalid;
            rsp = bresp;
            @(posedge sys_clk);
            if (++n > 100) tmo();
        end while (!hs);
    endtask

    task automatic rd(input logic [7:0] a);
        int   n;
        logic hs;
        n = 0; hs = 0;
        araddr <= a; arvalid <= 1'h1;
        while (!hs) begin
            @(negedge sys_clk);
            hs = arready;
            @(posedge sys_clk);
            if (hs) arvalid <= 1'h0;
            if (++n > 50) tmo();
        end
        do begin
            @(negedge sys_clk);
            hs = rvalid; rdv = rdata; rsp = rresp;
            @(posedge sys_clk);
            if (++n > 100) tmo();
        end while (!hs);
    endtask

    // ----------------------------------------
    // Clock and test sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        rstn = 0; awvalid = 0; wvalid = 0; arvalid = 0; bready = 1;
        rready = 1; wstrb = 4'hF; awaddr = '0; araddr = '0; wdata = '0;
        sw = flame_cfg_pkg::SW_RESET; fm = '0; cmdB = 0; lineOk = 1;
        measIntensity = '0; measFreq = '0; err_count = 0; n_compared = 0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'h1;
        @(posedge sys_clk);
        look(4, 32'h6);
        rd(flame_cfg_pkg::OFS_STATUS);
        chk(rdv, 32'h60);
        rd(8'h20);
        chk({30'h0, rsp}, {30'h0, flame_cfg_pkg::RESP_SLVERR});
        wr(flame_cfg_pkg::OFS_INT_EN, 32'h1);
        chk({30'h0, rsp}, {30'h0, flame_cfg_pkg::RESP_OKAY});
        $display("reset and bus test done");
        for (c = 4'h0; c < 4'hF; c = c + 4'h5) begin
            sw.intA <= c + 4'h0; sw.intB <= c + 4'h0;
            measIntensity <= {c, 8'h00};
            await(0, 32'h0, 60);
            measIntensity <= {c, 8'h01};
            await(0, 32'h1, 20);
        end
        look(6, 32'h1);
        wr(flame_cfg_pkg::OFS_INT_CLR, 32'h1F);
        look(6, 32'h0);
        $display("intensity test done");
        sw.intA <= 4'h0; sw.frqA <= 4'hA; measFreq <= 12'h096;
        await(0, 32'h0, 60);
        look(5, 32'h1);
        look(6, 32'h0);
        rd(flame_cfg_pkg::OFS_INT_STAT);
        chk({31'h0, rdv[1]}, 32'h1);
        measFreq <= 12'h097;
        await(0, 32'h1, 20);
        look(6, 32'h1);
        measFreq <= 12'h064;
        repeat (15) @(posedge sys_clk);
        look(0, 32'h1);
        await(0, 32'h0, 60);
        sw.frqA <= 4'h0;
        await(5, 32'h0, 10);
        $display("flicker test done");
        for (c = 4'h0; c < 4'h8; c++) begin
            // Range B code never equals the previous or the range A curve
            sw.dip[4:2] <= c[2:0];
            sw.dip[7:5] <= c[2:0] ^ 3'h4;
            cmdB <= 1'h0;
            await(3, 32'h0, 10);
            await(4, {29'h0, ~c[2:0]}, 10);
            cmdB <= 1'h1;
            await(3, 32'h1, 10);
            await(4, {29'h0, ~c[2:0] ^ 3'h4}, 10);
        end
        sw.intB <= 4'hF; measIntensity <= 12'h200;
        await(0, 32'h0, 60);
        lineOk <= 1'h0;
        await(3, 32'h0, 10);
        await(0, 32'h1, 20);
        $display("range test done");
        fm.intA <= 4'h1;
        await(1, 32'h1, 10);
        repeat (20) @(posedge sys_clk);
        fm <= '0;
        await(1, 32'h0, 10);
        fm.frqB <= 4'h8;
        repeat (25) @(posedge sys_clk);
        fm <= '0;
        look(2, 32'h0);
        fm.dip <= 8'h08;
        repeat (25) @(posedge sys_clk);
        look(2, 32'h0);
        await(2, 32'h1, 60);
        look(0, 32'h0);
        rd(flame_cfg_pkg::OFS_STATUS);
        chk(rdv, 32'h6);
        rd(flame_cfg_pkg::OFS_INT_STAT);
        chk(rdv, 32'h1F);
        rd(flame_cfg_pkg::OFS_MEAS);
        chk(rdv, 32'h0064_0200);
        $display("mismatch test done");
        final_report();
    end
endmodule
`default_nettype wire
